// ### src/probe_position_latch.sv
// Two-channel probe position latch with its control and status objects
`timescale 1ns/1ps
`include "probe_latch_defs.svh"
module probe_position_latch (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic probe_input_one,
    input wire logic probe_input_two,
    input wire logic zero_pulse,
    input wire logic [31:0] feedback_position,
    input wire logic obj_write,
    input wire logic obj_read,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    output logic [31:0] obj_rdata,
    output logic obj_rvalid,
    output logic obj_error
);
    logic [15:0] control;
    logic [15:0] next_control;
    logic [`NUM_CHANNELS-1:0] prev_src;
    logic [`NUM_CHANNELS-1:0] next_prev_src;
    logic [`NUM_CHANNELS-1:0] rise_stored;
    logic [`NUM_CHANNELS-1:0] next_rise_stored;
    logic [`NUM_CHANNELS-1:0] fall_stored;
    logic [`NUM_CHANNELS-1:0] next_fall_stored;
    logic [1:0] count [`NUM_CHANNELS];
    logic [1:0] next_count [`NUM_CHANNELS];
    probe_latch_pkg::arm_state_t state [`NUM_CHANNELS];
    probe_latch_pkg::arm_state_t next_state [`NUM_CHANNELS];
    logic [`NUM_POS-1:0] pos_wr;
    logic [`NUM_CHANNELS-1:0] src_now;
    logic [15:0] status;
    logic [31:0] store_rdata;
    probe_latch_pkg::pos_slot_t rd_slot;
    logic rd_is_pos;
    logic [31:0] reg_rdata;
    logic [31:0] next_reg_rdata;
    logic next_rvalid;
    logic next_error;
    logic rd_from_store;
    logic next_rd_from_store;
    logic [`NUM_CHANNELS-1:0] ch_enable;
    logic [`NUM_CHANNELS-1:0] ch_mode;
    logic [`NUM_CHANNELS-1:0] ch_source;
    logic [`NUM_CHANNELS-1:0] ch_rise_en;
    logic [`NUM_CHANNELS-1:0] ch_fall_en;
    logic [`NUM_CHANNELS-1:0] rise_ev;
    logic [`NUM_CHANNELS-1:0] fall_ev;

    // Slice one channel's byte out of a 16-bit object
    function automatic logic [7:0] ch_byte(input logic [15:0] word, input int ch);
        ch_byte = (ch == 0) ? word[`CH_BYTE_W-1:0] : word[`CH2_BASE +: `CH_BYTE_W];
    endfunction

    // Channel and edge to position slot, used by both read decode and capture strobes
    function automatic probe_latch_pkg::pos_slot_t pos_slot(input int ch, input logic fall);
        pos_slot = probe_latch_pkg::pos_slot_t'(2 * ch + int'(fall));
    endfunction

    // Per-channel control fields; both channels share one layout, each in its own byte
    always_comb
    begin
        logic [7:0] fields;
        fields = 8'h00;
        // Channel one reads the low byte and channel two the high byte
        for (int ch = 0; ch < `NUM_CHANNELS; ch++)
        begin
            fields = ch_byte(control, ch);
            ch_enable[ch] = fields[`F_ENABLE];
            ch_mode[ch] = fields[`F_MODE];
            ch_source[ch] = fields[`F_SOURCE];
            ch_rise_en[ch] = fields[`F_RISE_EN];
            ch_fall_en[ch] = fields[`F_FALL_EN];
        end
    end

    // Source select per channel; the zero pulse is shared by both channels
    // Switching source while armed can show one false edge, so set the source before enabling
    always_comb
    begin
        src_now[0] = ch_source[0] ? zero_pulse : probe_input_one;
        src_now[1] = ch_source[1] ? zero_pulse : probe_input_two;
    end

    // Edges are found against last cycle's level; a direction whose enable is low never fires
    always_comb
    begin
        for (int ch = 0; ch < `NUM_CHANNELS; ch++)
        begin
            rise_ev[ch] = ch_rise_en[ch] && src_now[ch] && !prev_src[ch];
            fall_ev[ch] = ch_fall_en[ch] && !src_now[ch] && prev_src[ch];
        end
        next_prev_src = src_now;
    end

    // Control object write; reserved bits are dropped so they cannot steer anything
    always_comb
    begin
        next_control = control;
        if (obj_write && obj_index == `IDX_CONTROL)
        begin
            next_control = {obj_wdata[15:8] & `CTRL_USED_MASK, obj_wdata[7:0] & `CTRL_USED_MASK};
        end
    end

    // Capture engine, one iteration per channel with no shared state
    always_comb
    begin
        logic hit;
        hit = 1'b0;
        pos_wr = '0;
        for (int ch = 0; ch < `NUM_CHANNELS; ch++)
        begin
            next_rise_stored[ch] = rise_stored[ch];
            next_fall_stored[ch] = fall_stored[ch];
            next_count[ch] = count[ch];
            next_state[ch] = state[ch];
            // One source cannot rise and fall in the same cycle
            hit = rise_ev[ch] || fall_ev[ch];
            case (state[ch])
                probe_latch_pkg::ST_IDLE:
                begin
                    // Disabled: flags and counter stay cleared, enable re-arms
                    next_rise_stored[ch] = 1'b0;
                    next_fall_stored[ch] = 1'b0;
                    next_count[ch] = 2'h0;
                    // Arming takes one edge, so the status enable lags the control bit by a cycle
                    if (ch_enable[ch])
                    begin
                        next_state[ch] = probe_latch_pkg::ST_ARMED;
                    end
                end
                probe_latch_pkg::ST_ARMED:
                begin
                    if (!ch_enable[ch])
                    begin
                        // Clear together with the state change so status never shows stale flags
                        next_state[ch] = probe_latch_pkg::ST_IDLE;
                        next_rise_stored[ch] = 1'b0;
                        next_fall_stored[ch] = 1'b0;
                        next_count[ch] = 2'h0;
                    end
                    // Single mode: any stored flag blocks further captures until re-armed
                    else if (hit && (ch_mode[ch] || !(rise_stored[ch] || fall_stored[ch])))
                    begin
                        // Capture the position into the slot for this edge
                        pos_wr[pos_slot(ch, fall_ev[ch])] = 1'b1;
                        next_rise_stored[ch] = rise_stored[ch] | rise_ev[ch];
                        next_fall_stored[ch] = fall_stored[ch] | fall_ev[ch];
                        if (ch_mode[ch])
                        begin
                            next_count[ch] = count[ch] + 2'h1; // Wraps 3 to 0
                        end
                    end
                end
                default:
                begin
                    next_state[ch] = probe_latch_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Status object assembly; reserved bits forced to zero
    always_comb
    begin
        status = 16'h0000;
        for (int ch = 0; ch < `NUM_CHANNELS; ch++)
        begin
            status[ch * `CH2_BASE + `F_ENABLE] = (state[ch] == probe_latch_pkg::ST_ARMED);
            status[ch * `CH2_BASE + `S_RISE_STORED] = rise_stored[ch];
            status[ch * `CH2_BASE + `S_FALL_STORED] = fall_stored[ch];
            status[ch * `CH2_BASE + `S_COUNT_LO +: 2] = count[ch];
        end
    end

    // Read decode; positions come from the store one cycle later, like other objects
    always_comb
    begin
        next_reg_rdata = 32'h0000_0000;
        next_rvalid = obj_read;
        next_error = 1'b0;
        next_rd_from_store = 1'b0;
        rd_is_pos = 1'b0;
        rd_slot = probe_latch_pkg::pos_slot_t'(0);
        if (obj_index == `IDX_CONTROL)
        begin
            next_reg_rdata = {16'h0000, control};
        end
        else if (obj_index == `IDX_STATUS)
        begin
            next_reg_rdata = {16'h0000, status};
        end
        else if (obj_index == `IDX_CH1_RISE)
        begin
            rd_is_pos = 1'b1;
            rd_slot = pos_slot(0, 1'b0);
        end
        else if (obj_index == `IDX_CH1_FALL)
        begin
            rd_is_pos = 1'b1;
            rd_slot = pos_slot(0, 1'b1);
        end
        else if (obj_index == `IDX_CH2_RISE)
        begin
            rd_is_pos = 1'b1;
            rd_slot = pos_slot(1, 1'b0);
        end
        else if (obj_index == `IDX_CH2_FALL)
        begin
            rd_is_pos = 1'b1;
            rd_slot = pos_slot(1, 1'b1);
        end
        else
        begin
            next_error = obj_read || obj_write; // Unknown object answers with an error
        end
        next_rd_from_store = rd_is_pos;
    end

    // Read data mux; the store output is already registered
    always_comb
    begin
        obj_rdata = rd_from_store ? store_rdata : reg_rdata;
    end

    // Positions live in their own store; its read data is already registered
    position_store u_store (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .wr_en(pos_wr),
        .wr_data(feedback_position),
        .rd_addr(rd_slot),
        .rd_data(store_rdata)
    );

    // Channel state, all frozen while the clock enable is low
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            // Inputs idle low, so a low previous level keeps a false edge from following reset
            control <= `CONTROL_RESET;
            prev_src <= '0;
            rise_stored <= '0;
            fall_stored <= '0;
            for (int ch = 0; ch < `NUM_CHANNELS; ch++)
            begin
                count[ch] <= 2'h0;
                state[ch] <= probe_latch_pkg::ST_IDLE;
            end
        end
        else if (ce)
        begin
            control <= next_control;
            prev_src <= next_prev_src;
            rise_stored <= next_rise_stored;
            fall_stored <= next_fall_stored;
            count <= next_count;
            state <= next_state;
        end
    end

    // Object answer registers; a low clock enable also holds a pending answer
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            reg_rdata <= 32'h0000_0000;
            obj_rvalid <= 1'b0;
            obj_error <= 1'b0;
            rd_from_store <= 1'b0;
        end
        else if (ce)
        begin
            reg_rdata <= next_reg_rdata;
            obj_rvalid <= next_rvalid;
            obj_error <= next_error;
            rd_from_store <= next_rd_from_store;
        end
    end
endmodule // probe_position_latch

// ### src/probe_latch_defs.svh
// Register indices, field positions and reset values of the probe position latch
`ifndef PROBE_LATCH_DEFS_SVH
`define PROBE_LATCH_DEFS_SVH
`define IDX_CONTROL 16'h60b8
`define IDX_STATUS 16'h60b9
`define IDX_CH1_RISE 16'h60ba
`define IDX_CH1_FALL 16'h60bb
`define IDX_CH2_RISE 16'h60bc
`define IDX_CH2_FALL 16'h60bd
`define CONTROL_RESET 16'h0000
`define CH_BYTE_W 8
`define CH2_BASE 8
`define F_ENABLE 0
`define F_MODE 1
`define F_SOURCE 2
`define F_RISE_EN 4
`define F_FALL_EN 5
`define S_RISE_STORED 1
`define S_FALL_STORED 2
`define S_COUNT_LO 6
`define CTRL_USED_MASK 8'h37
`define POS_RESET 32'h0000_0000
`define NUM_CHANNELS 2
`define NUM_POS 4
`endif

// ### src/probe_latch_pkg.sv
// Types shared by the probe position latch files
package probe_latch_pkg;
    typedef logic [31:0] position_t;
    typedef logic [1:0] pos_slot_t;
    typedef enum logic [0:0] {ST_IDLE, ST_ARMED} arm_state_t;
endpackage

// ### src/position_store.sv
// Small register memory for the four latched positions
`timescale 1ns/1ps
`include "probe_latch_defs.svh"
module position_store (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [`NUM_POS-1:0] wr_en,
    input wire logic [31:0] wr_data,
    input wire logic [1:0] rd_addr,
    output logic [31:0] rd_data
);
    logic [31:0] mem [`NUM_POS];
    logic [31:0] next_mem [`NUM_POS];
    logic [31:0] next_rd_data;

    // Each slot takes the shared position word when its strobe is high
    always_comb
    begin
        for (int i = 0; i < `NUM_POS; i++)
        begin
            next_mem[i] = wr_en[i] ? wr_data : mem[i];
        end
        next_rd_data = mem[rd_addr];
    end

    // Registered read keeps the data output glitch free
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < `NUM_POS; i++)
            begin
                mem[i] <= `POS_RESET;
            end
            rd_data <= `POS_RESET;
        end
        else if (ce)
        begin
            mem <= next_mem;
            rd_data <= next_rd_data;
        end
    end
endmodule // position_store

// ### dv/probe_latch_checker.sv
// Port assertions of the probe position latch
`timescale 1ns/1ps
`include "probe_latch_defs.svh"
module probe_latch_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic obj_write,
    input wire logic obj_read,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    input wire logic [31:0] obj_rdata,
    input wire logic obj_rvalid,
    input wire logic obj_error
);
    logic [15:0] ctl, next_ctl;
    logic known, st_rd, ctl_rd;
    assign known = obj_index >= `IDX_CONTROL && obj_index <= `IDX_CH2_FALL;
    assign st_rd = ce && obj_read && obj_index == `IDX_STATUS;
    assign ctl_rd = ce && obj_read && !obj_write && obj_index == `IDX_CONTROL;
    // Shadow of control; reserved bits dropped since the host may send junk there
    always_comb
    begin
        next_ctl = ctl;
        if (ce && obj_write && obj_index == `IDX_CONTROL)
            next_ctl = obj_wdata[15:0] & {2{`CTRL_USED_MASK}};
    end
    always_ff @(posedge clk)
    begin
        ctl <= rstn ? next_ctl : `CONTROL_RESET;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_read_answered: assert property (ce && obj_read && known |=> obj_rvalid && !obj_error)
        else $error("read of a known object not answered");
    a_bad_index: assert property (ce && (obj_read || obj_write) && !known |=> obj_error
        && (obj_rvalid == $past(obj_read)))
        else $error("unknown object not refused");
    a_valid_cause: assert property (obj_rvalid && $past(ce) |-> $past(obj_read))
        else $error("answer without request");
    a_write_silent: assert property (ce && obj_write && !obj_read && known |=> !obj_rvalid && !obj_error)
        else $error("write to known object answered");
    a_ctl_readback: assert property ($past(ctl_rd) |-> obj_rdata == {16'h0000, ctl})
        else $error("control read back wrong");
    a_status_reserved: assert property ($past(st_rd) |-> obj_rdata[31:16] == 16'h0000 && obj_rdata[5:3] == 3'h0
        && obj_rdata[13:11] == 3'h0)
        else $error("reserved status bits set");
    a_status_enable: assert property ($past(st_rd) && $past(ctl, 2) == ctl |-> obj_rdata[0] == ctl[0]
        && obj_rdata[8] == ctl[8])
        else $error("status enable differs from control");
    a_idle_clear: assert property ($past(st_rd) && $past(ctl, 2) == ctl |-> (ctl[0] || obj_rdata[7:0] == 8'h00)
        && (ctl[8] || obj_rdata[15:8] == 8'h00))
        else $error("disabled channel keeps flags");
endmodule // probe_latch_checker
bind probe_position_latch probe_latch_checker chk (.clk(clk), .rstn(rstn), .ce(ce), .obj_write(obj_write),
    .obj_read(obj_read), .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_rvalid(obj_rvalid), .obj_error(obj_error));

// ### dv/host_model.sv
// Host controller model issuing object reads and writes
`timescale 1ns/1ps
`include "probe_latch_defs.svh"
module host_model (
    input wire logic clk,
    output logic obj_write,
    output logic obj_read,
    output logic [15:0] obj_index,
    output logic [31:0] obj_wdata
);
    logic [32:0] exp_q [$];
    bit strict = 1;
    int idle_cycles = 0;
    initial
    begin
        obj_write = 1'b0;
        obj_read = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h0;
    end
    // One request, noted first so the answer always finds its note waiting
    task automatic req(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic err);
        if (err || !w)
            exp_q.push_back({err, d});
        repeat (idle_cycles) @(posedge clk);
        @(posedge clk);
        #1;
        obj_write = w;
        obj_read = !w;
        obj_index = idx;
        obj_wdata = (strict && w) ? d & {16'h0000, {2{`CTRL_USED_MASK}}} : d;
        @(posedge clk);
        #1;
        obj_write = 1'b0;
        obj_read = 1'b0;
        obj_index = ~idx; // Stale index must not be trusted
        obj_wdata = ~obj_wdata;
    endtask
endmodule // host_model

// ### dv/test_probe_position_latch.sv
// Self-checking bench of the probe position latch
`timescale 1ns/1ps
`include "probe_latch_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_probe_position_latch;
    logic clk, rstn, ce, obj_write, obj_read, obj_rvalid, obj_error;
    logic [2:0] trig; // Probe one, probe two, zero pulse
    logic [15:0] obj_index;
    logic [31:0] obj_wdata, obj_rdata;
    probe_latch_pkg::position_t pos;
    probe_latch_pkg::position_t p [4];
    logic [32:0] e;
    int n_fail = 0;
    int checks_done = 0;
    host_model host (.clk(clk), .obj_write(obj_write), .obj_read(obj_read), .obj_index(obj_index),
        .obj_wdata(obj_wdata));
    probe_position_latch dut (.clk(clk), .rstn(rstn), .ce(ce), .probe_input_one(trig[0]),
        .probe_input_two(trig[1]), .zero_pulse(trig[2]), .feedback_position(pos), .obj_write(obj_write),
        .obj_read(obj_read), .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
        .obj_rvalid(obj_rvalid), .obj_error(obj_error));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("Checks %0d, failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] d);
        host.req(1'b0, idx, d, 1'b0);
    endtask
    task automatic wr(input logic [15:0] d);
        host.req(1'b1, `IDX_CONTROL, {16'h0000, d}, 1'b0);
    endtask
    task automatic rd_pos();
        for (int i = 0; i < 4; i++)
            rd(`IDX_CH1_RISE + 16'(i), p[i]);
    endtask
    // Move one trigger line, fresh position held steady across the capture edge
    task automatic hit(input int k, input logic lvl, input logic [3:0] m);
        repeat (2) @(posedge clk);
        #1;
        pos = $urandom;
        trig[k] = lvl;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++)
            if (m[i])
                p[i] = pos;
    endtask
    // Each answer is paired with the oldest note
    always @(negedge clk)
    begin
        if (obj_rvalid === 1'b1 || obj_error === 1'b1)
        begin
            // An answer with no note waiting is a stray answer, not a pass
            if (host.exp_q.size() == 0)
                `CHK("answer_noted", 1'b0, 1'b1)
            else
            begin
                e = host.exp_q.pop_front();
                if (e[32]) `CHK("obj_error", 1'b1, obj_error)
                else `CHK("obj_rdata", e[31:0], obj_rdata)
            end
        end
    end
    // Whole run is well under 3000 cycles; this bound only cuts a hang
    initial
    begin
        #(25 * 6000);
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(97));
        rstn = 1'b0;
        ce = 1'b1;
        trig = 3'h0;
        pos = `POS_RESET;
        for (int i = 0; i < 4; i++)
            p[i] = `POS_RESET;
        repeat (5) @(posedge clk);
        #1;
        rstn = 1'b1;
        // Reset state, then refused indices and junk in reserved control bits
        for (int i = 0; i < 6; i++)
            rd(`IDX_CONTROL + 16'(i), 32'h0);
        host.req(1'b0, 16'h60be, 32'h0, 1'b1);
        host.req(1'b1, 16'h60b7, 32'h0, 1'b1);
        host.strict = 0;
        wr(16'hc8c8);
        host.strict = 1;
        rd(`IDX_CONTROL, 32'h0);
        rd(`IDX_STATUS, 32'h0);
        // Channel one single mode on probe one rising edges
        wr(16'h0011);
        rd(`IDX_STATUS, 32'h0001);
        hit(0, 1'b1, 4'b0001);
        hit(1, 1'b1, 4'b0000);
        hit(0, 1'b0, 4'b0000);
        hit(0, 1'b1, 4'b0000);
        hit(1, 1'b0, 4'b0000);
        hit(0, 1'b0, 4'b0000);
        host.req(1'b1, `IDX_CH1_RISE, 32'h0, 1'b0);
        rd_pos();
        rd(`IDX_STATUS, 32'h0003);
        // Disable clears flags, frozen clock idles, re-enable re-arms
        wr(16'h0000);
        @(posedge clk);
        #1;
        ce = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        ce = 1'b1;
        rd(`IDX_STATUS, 32'h0);
        wr(16'h0011);
        hit(0, 1'b1, 4'b0001);
        rd(`IDX_CH1_RISE, p[0]);
        wr(16'h0000);
        hit(0, 1'b0, 4'b0000);
        // Both channels continuous on the zero pulse, both edges, slow host
        wr(16'h3737);
        host.idle_cycles = 2;
        for (int i = 0; i < 5; i++)
            hit(2, !i[0], i[0] ? 4'b1010 : 4'b0101);
        rd_pos();
        rd(`IDX_STATUS, 32'h4747);
        host.idle_cycles = 0;
        wr(16'h0000);
        hit(2, 1'b0, 4'b0000);
        // Channel two single on probe two falling edges only
        wr(16'h2100);
        hit(1, 1'b1, 4'b0000);
        hit(1, 1'b0, 4'b1000);
        hit(0, 1'b1, 4'b0000);
        hit(2, 1'b1, 4'b0000);
        hit(2, 1'b0, 4'b0000);
        rd_pos();
        rd(`IDX_STATUS, 32'h0500);
        repeat (4) @(posedge clk);
        `CHK("pending", 0, host.exp_q.size())
        tally_and_finish();
    end
endmodule // test_probe_position_latch
